// File: include/oamie_dec_if.sv
// Purpose: Carries decoded instruction fields from decoder to datapath.
// Assumes: One instruction per clock.
// Notes:   Decoder drives, datapath consumes.
`timescale 1ns/1ps
interface oamie_dec_if;
   import oamie_pkg::*;
   oamie_op_t          op;
   logic [7:0]         literal;
   logic [4:0]         faddr;
   logic               dest_file;
   modport dec (output op, output literal, output faddr, output dest_file);
   modport exe (input op, input literal, input faddr, input dest_file);
endinterface

// File: include/oamie_pkg.sv
// Purpose: Constants shared by the or/move execution datapath.
// Assumes: 12-bit instruction words, 8-bit data, 5-bit file addresses.
// Notes:   Opcode fields sit in the upper bits of the instruction word.
package oamie_pkg;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned FADDR_W   = 5;
   localparam int unsigned INSTR_W   = 12;
   localparam int unsigned DEST_BIT  = 5;
   localparam logic [3:0]  OP_OR_LIT   = 4'hd;
   localparam logic [3:0]  OP_LOAD_LIT = 4'hc;
   localparam logic [5:0]  OP_OR_FILE  = 6'h04;
   localparam logic [5:0]  OP_MOVE_FILE = 6'h08;
   localparam logic [7:0]  ACC_RESET   = 8'h00;
   localparam logic        ZERO_RESET  = 1'b0;
   localparam logic        STROBE_RESET = 1'b0;
   localparam logic [4:0]  WADDR_RESET = 5'h00;
   localparam logic [7:0]  WDATA_RESET = 8'h00;
   typedef enum logic [4:0]
   {
      OAMIE_NONE      = 5'h01,
      OAMIE_OR_LIT    = 5'h02,
      OAMIE_OR_FILE   = 5'h04,
      OAMIE_MOVE_FILE = 5'h08,
      OAMIE_LOAD_LIT  = 5'h10
   } oamie_op_t;
endpackage

// File: logic/oamie_decode.sv
// Purpose: Decodes a 12-bit instruction word into one of four operations.
// Assumes: Instruction word is stable for the cycle it is valid.
// Notes:   Unrecognised words decode to no operation.
`timescale 1ns/1ps
module oamie_decode
   import oamie_pkg::*;
(
   // Instruction
   input  wire logic [11:0] instr,
   input  wire logic        instr_valid,
   // Decoded fields
   oamie_dec_if.dec         d
);
   wire is_or_lit   = instr_valid && instr[11:8] == OP_OR_LIT;
   wire is_load_lit = instr_valid && instr[11:8] == OP_LOAD_LIT;
   wire is_or_file  = instr_valid && instr[11:6] == OP_OR_FILE;
   wire is_move     = instr_valid && instr[11:6] == OP_MOVE_FILE;

   assign d.op = is_or_lit   ? OAMIE_OR_LIT :
                 is_or_file  ? OAMIE_OR_FILE :
                 is_move     ? OAMIE_MOVE_FILE :
                 is_load_lit ? OAMIE_LOAD_LIT : OAMIE_NONE;
   assign d.literal   = instr[7:0];
   assign d.faddr     = instr[4:0];
   assign d.dest_file = instr[DEST_BIT];
endmodule

// File: logic/oamie_exec.sv
// Purpose: Executes or_literal_into_acc, or_acc_with_file, move_file_to_dest
//          and load_literal_into_acc on an 8-bit accumulator and zero flag.
// Assumes: File register read data for instr's address is valid in the same
//          cycle; the file write port takes one strobe per cycle.
// Notes:   All outputs but file_raddr are registered, so results appear one clock later.
//          A write-back reaches the file one clock after issue, so an instruction issued
//          right behind it that reads the same register sees the value before the write.
// Summary of operation
// - Opcode 1101 ORs literal into accumulator, updates zero flag.
// - Pattern 000100 ORs accumulator with file register, updates zero flag.
// - Destination bit 0 writes accumulator, 1 writes file register back.
// - Pattern 001000 moves file register to accumulator or back to file.
// - Move updates zero flag even when destination is the file register.
`timescale 1ns/1ps
module oamie_exec
   import oamie_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Instruction
   input  wire logic [11:0] instr,
   input  wire logic        instr_valid,
   // File register read port
   output logic      [4:0]  file_raddr,
   input  wire logic [7:0]  file_rdata,
   // File register write port
   output logic             file_we,
   output logic      [4:0]  file_waddr,
   output logic      [7:0]  file_wdata,
   // Core state
   output logic      [7:0]  acc,
   output logic             zero_flag,
   output logic             zero_we
);
   oamie_dec_if d ();

   // The decoder turns the word into one form and its operand fields.
   oamie_decode u_decode
   (
      .instr       (instr),
      .instr_valid (instr_valid),
      .d           (d)
   );

   // The read address is combinational from the word so data is available this cycle.
   wire       [4:0] raddr_w     = instr[4:0];
   wire       [7:0] or_lit_res;
   wire       [7:0] or_file_res;
   wire       [7:0] move_res;
   wire       [7:0] load_res;

   // One lane per data bit builds the candidate result of every form.
   for (genvar b = 0; b < DATA_W; b++)
   begin : g_lane
      assign or_lit_res[b]  = acc[b] | d.literal[b];
      assign or_file_res[b] = acc[b] | file_rdata[b];
      assign move_res[b]    = file_rdata[b];
      assign load_res[b]    = d.literal[b];
   end

   logic      [7:0] result;
   logic            wr_acc;
   logic            wr_file;
   logic            upd_zero;

   // Words that decode to no form keep every enable low, so acc, zero_flag and the file keep their values.
   always_comb
   begin
      result   = acc;
      wr_acc   = 1'b0;
      wr_file  = 1'b0;
      upd_zero = 1'b0;
      case (d.op)
         OAMIE_OR_LIT:
         begin
            result   = or_lit_res;
            wr_acc   = 1'b1;
            upd_zero = 1'b1;
         end
         OAMIE_OR_FILE:
         begin
            result   = or_file_res;
            wr_acc   = !d.dest_file;
            wr_file  = d.dest_file;
            upd_zero = 1'b1;
         end
         OAMIE_MOVE_FILE:
         begin
            result   = move_res;
            wr_acc   = !d.dest_file;
            wr_file  = d.dest_file;
            upd_zero = 1'b1;
         end
         OAMIE_LOAD_LIT:
         begin
            result   = load_res;
            wr_acc   = 1'b1;
            wr_file  = 1'b0;
            upd_zero = 1'b0;
         end
         OAMIE_NONE:
         begin
            result   = acc;
            wr_acc   = 1'b0;
            wr_file  = 1'b0;
            upd_zero = 1'b0;
         end
         default:
         begin
            result   = acc;
            wr_acc   = 1'b0;
            wr_file  = 1'b0;
            upd_zero = 1'b0;
         end
      endcase
   end

   // Zero detect ripples a clear test across the bits of the result.
   wire       [8:0] clear_run;
   assign clear_run[0] = 1'b1;
   for (genvar b = 0; b < DATA_W; b++)
   begin : g_zero
      assign clear_run[b+1] = clear_run[b] & ~result[b];
   end
   wire             result_zero     = clear_run[8];

   // Next values of the registered outputs.
   wire       [7:0] next_acc        = wr_acc ? result : acc;
   wire             next_zero       = upd_zero ? result_zero : zero_flag;
   wire             next_zero_we    = upd_zero;
   wire             next_file_we    = wr_file;
   wire       [4:0] next_file_waddr = d.faddr;
   wire       [7:0] next_file_wdata = result;

   assign file_raddr = raddr_w;

   // Accumulator.
   // It holds whenever the form that ran writes its result to the file instead.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc <= ACC_RESET;
      end
      else
      begin
         acc <= next_acc;
      end
   end

   // Zero flag.
   // The literal load and unrecognised words leave it as it stands.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         zero_flag <= ZERO_RESET;
      end
      else
      begin
         zero_flag <= next_zero;
      end
   end

   // Zero update strobe.
   // It is high for the one cycle after a form that tests its result.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         zero_we <= STROBE_RESET;
      end
      else
      begin
         zero_we <= next_zero_we;
      end
   end

   // File write strobe.
   // It is high for the one cycle after a form whose destination is the file.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         file_we <= STROBE_RESET;
      end
      else
      begin
         file_we <= next_file_we;
      end
   end

   // File write address.
   // It follows the word every cycle and only matters while file_we is high.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         file_waddr <= WADDR_RESET;
      end
      else
      begin
         file_waddr <= next_file_waddr;
      end
   end

   // File write data.
   // It shows the last result every cycle, so the file must qualify it with file_we.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         file_wdata <= WDATA_RESET;
      end
      else
      begin
         file_wdata <= next_file_wdata;
      end
   end
endmodule

// File: verif/oamie_exec_monitor.sv
// Purpose: Port checks of the or/move datapath.
// Assumes: Results show one clock after issue.
// Notes:   Bound to every oamie_exec.
`timescale 1ns/1ps
module oamie_exec_monitor
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [11:0] instr,
   input wire logic        instr_valid,
   input wire logic [4:0]  file_raddr,
   input wire logic [7:0]  file_rdata,
   input wire logic        file_we,
   input wire logic [4:0]  file_waddr,
   input wire logic [7:0]  file_wdata,
   input wire logic [7:0]  acc,
   input wire logic        zero_flag,
   input wire logic        zero_we
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   or_lit_a: assert property (instr_valid && instr[11:8] == 4'hd
      |=> zero_we && acc == ($past(acc) | $past(instr[7:0])) && zero_flag == (acc == 8'h00)) else $error("or lit");
   or_file_a: assert property (instr_valid && instr[11:5] == 7'h08
      |=> zero_we && !file_we && acc == ($past(acc) | $past(file_rdata))) else $error("or file");
   or_back_a: assert property (instr_valid && instr[11:5] == 7'h09
      |=> file_we && $stable(acc) && file_wdata == ($past(acc) | $past(file_rdata))) else $error("or back");
   move_acc_a: assert property (instr_valid && instr[11:5] == 7'h10
      |=> !file_we && acc == $past(file_rdata)) else $error("move acc");
   move_test_a: assert property (instr_valid && instr[11:5] == 7'h11
      |=> file_we && zero_we && $stable(acc) && zero_flag == ($past(file_rdata) == 8'h00)) else $error("move test");
   load_lit_a: assert property (instr_valid && instr[11:8] == 4'hc
      |=> !zero_we && $stable(zero_flag) && acc == $past(instr[7:0])) else $error("load lit");
   cover property (file_we);
   cover property (zero_we && zero_flag);
   cover property (instr_valid && instr[11:8] == 4'hc);
endmodule
bind oamie_exec oamie_exec_monitor i_mon (.*);

// File: verif/tb_oamie_exec.sv
// Purpose: Random self-checking run of the or/move datapath.
// Assumes: File registers are a static bench memory.
// Notes:   Each note predicts the outputs one clock after issue.
`timescale 1ns/1ps
module tb_oamie_exec;
   logic        clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, file_we, zero_flag, zero_we;
   logic [11:0] instr = 12'h000;
   logic [4:0]  file_raddr, file_waddr;
   logic [7:0]  file_rdata, file_wdata, acc, mem [32];
   logic [23:0] q [$];
   int          n_errors = 0, total_checks = 0;
   assign file_rdata = mem[file_raddr];
   oamie_exec i_dut (.*);
   initial forever #5 clk = ~clk;
   task check(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(negedge clk)
      if (q.size() > 1)
         check({acc, zero_flag, zero_we, file_we, file_we ? {file_waddr, file_wdata} : 13'h0}, q.pop_front());
   initial
   begin
      logic [7:0] m_acc, lit, r;
      logic       m_z, ve, ze, fe;
      int         op, a, d;
      m_acc = 8'h00;
      m_z = 1'b0;
      void'($urandom(32'hb7a417c3));
      foreach (mem[i]) mem[i] = (i < 2) ? 8'h00 : 8'($urandom);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 400; i++)
      begin
         op = $urandom % 5;
         a = $urandom % 32;
         d = $urandom % 2;
         lit = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
         ve = i > 0 && $urandom % 8 != 0;
         r = (op == 0) ? m_acc | lit : (op == 1) ? m_acc | mem[a] : (op == 2) ? mem[a] : lit;
         ze = ve && op < 3;
         fe = ze && op > 0 && d == 1;
         if (ve && op < 4 && !fe)
            m_acc = r;
         if (ze)
            m_z = r == 8'h00;
         @(posedge clk);
         rst <= 1'b0;
         instr_valid <= ve;
         instr <= (op == 0) ? {4'hd, lit} : (op == 3) ? {4'hc, lit} : (op == 4) ? {4'h3, lit} :
                  {2'b00, 2'(op), 2'b00, 1'(d), 5'(a)};
         q.push_back({m_acc, m_z, ze, fe, fe ? {5'(a), r} : 13'h0});
      end
      @(posedge clk);
      instr_valid <= 1'b0;
      q.push_back({m_acc, m_z, 2'b00, 13'h0});
      @(posedge clk);
      @(posedge clk);
      tally_and_finish();
   end
endmodule
